// File: rtl/ausr_core.sv
/*
 * Asynchronous serial transmitter and receiver with baud divider and
 * register file. Assumes inputs synchronous to sys_clk and a master that
 * never issues read and write strobes in the same cycle.
 */
// Local design decisions: the plain strobed port and the register offsets.

// Summary of operation
// - Async only while clocked-mode bit clear
// - NRZ frame: start, eight/nine data, stop
// - Data bits travel least significant first
// - Independent tx and rx, shared format, rate
// - Divider gives x16 or x64 bit rate
// - No parity generation or checking
// - Reload shifter only after stop bit
// - One-cycle transfer sets buffer-empty flag
// - Empty flag not writable, cleared by load
// - Flag updates second cycle after write
// - Transmit interrupt gated by its enable
// - Shifter-empty status bit, no interrupt
// - Setting transmit enable sets empty flag
// - Ninth bit sent from stored value
// - Buffer write starts transmission when enabled
// - Receiver samples at sixteen times bit rate
// - Continuous-receive enables; ninth-enable selects nine
// - Frame sets complete flag, gated interrupt
// - Clearing continuous-receive clears overrun error
// - Interrupt needs global and peripheral enables
module ausr_core #(
	parameter int ADDR_W = 4
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	input  wire logic              serial_input,
	output logic                   serial_output,
	output logic                   cpu_irq
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA  = 4'b0100,
		TX_STOP  = 4'b1000
	} ausr_tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA  = 4'b0100,
		RX_STOP  = 4'b1000
	} ausr_rx_state_t;

	ausr_pkg::ausr_frame_cfg_t cfg;
	ausr_tx_state_t            tx_state_reg;
	ausr_rx_state_t            rx_state_reg;
	logic [7:0]                irq_control_reg;
	logic [7:0]                enables_reg;
	logic [7:0]                priorities_reg;
	logic [7:0]                divisor_high_reg;
	logic [7:0]                divisor_low_reg;
	logic                      port_enable_reg;
	logic                      rx_ninth_en_reg;
	logic                      cont_rx_en_reg;
	logic                      tx_ninth_en_reg;
	logic                      tx_enable_reg;
	logic                      clocked_mode_reg;
	logic                      high_speed_reg;
	logic                      tx_ninth_val_reg;
	logic                      wide_divider_reg;
	logic [7:0]                tx_buf_reg;
	logic                      tx_full_reg;
	logic                      tx_empty_flag_reg;
	logic [8:0]                tx_shift_reg;
	logic [3:0]                tx_tick_reg;
	logic [3:0]                tx_bits_reg;
	logic                      tx_load;
	logic [15:0]               brg_cnt_reg;
	logic [1:0]                pre_cnt_reg;
	logic                      brg_tick;
	logic                      s16_tick;
	logic [8:0]                rx_shift_reg;
	logic [3:0]                rx_tick_reg;
	logic [3:0]                rx_bits_reg;
	logic                      rx_done_reg;
	logic                      rx_stop_ok_reg;
	logic [7:0]                rx_buf_reg;
	logic                      rx_ninth_reg;
	logic                      rx_full_reg;
	logic                      framing_err_reg;
	logic                      overrun_err_reg;
	logic                      wr_rx_status;
	logic                      wr_tx_status;
	logic                      wr_tx_buf;
	logic                      rd_rx_buf;
	logic                      tx_irq;
	logic                      rx_irq;

	// ****************************************
	// Shared configuration
	// ****************************************
	// Async only with port on and clocked mode off
	assign cfg.active   = port_enable_reg & ~clocked_mode_reg;
	assign cfg.x16_mode = high_speed_reg | wide_divider_reg;
	assign cfg.divisor  = wide_divider_reg ? {divisor_high_reg, divisor_low_reg} : {8'h00, divisor_low_reg};

	// Register port decode
	assign wr_rx_status = reg_wr && (reg_addr == ADDR_W'(ausr_pkg::RX_CONTROL_STATUS_IDX));
	assign wr_tx_status = reg_wr && (reg_addr == ADDR_W'(ausr_pkg::TX_CONTROL_STATUS_IDX));
	assign wr_tx_buf    = reg_wr && (reg_addr == ADDR_W'(ausr_pkg::TX_HOLDING_BUFFER_IDX));
	assign rd_rx_buf    = reg_rd && (reg_addr == ADDR_W'(ausr_pkg::RX_BUFFER_IDX));

	// ****************************************
	// Software registers
	// ****************************************
	// Plain read/write control bits
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_control_reg  <= ausr_pkg::REG_RESET;
			enables_reg      <= ausr_pkg::REG_RESET;
			priorities_reg   <= ausr_pkg::REG_RESET;
			divisor_high_reg <= ausr_pkg::REG_RESET;
			divisor_low_reg  <= ausr_pkg::REG_RESET;
			port_enable_reg  <= 1'b0;
			rx_ninth_en_reg  <= 1'b0;
			cont_rx_en_reg   <= 1'b0;
			tx_ninth_en_reg  <= 1'b0;
			tx_enable_reg    <= 1'b0;
			clocked_mode_reg <= 1'b0;
			high_speed_reg   <= 1'b0;
			tx_ninth_val_reg <= 1'b0;
			wide_divider_reg <= 1'b0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_W'(ausr_pkg::IRQ_CONTROL_IDX):      irq_control_reg  <= reg_wdata;
				ADDR_W'(ausr_pkg::PERIPH_ENABLES_1_IDX): enables_reg      <= reg_wdata;
				ADDR_W'(ausr_pkg::PERIPH_PRIO_1_IDX):    priorities_reg   <= reg_wdata;
				ADDR_W'(ausr_pkg::DIVISOR_HIGH_IDX):     divisor_high_reg <= reg_wdata;
				ADDR_W'(ausr_pkg::DIVISOR_LOW_IDX):      divisor_low_reg  <= reg_wdata;
				ADDR_W'(ausr_pkg::RATE_CONTROL_IDX):     wide_divider_reg <= reg_wdata[ausr_pkg::WIDE_DIVIDER_BIT];
				ADDR_W'(ausr_pkg::RX_CONTROL_STATUS_IDX): begin
					port_enable_reg <= reg_wdata[ausr_pkg::PORT_ENABLE_BIT];
					rx_ninth_en_reg <= reg_wdata[ausr_pkg::RX_NINTH_EN_BIT];
					cont_rx_en_reg  <= reg_wdata[ausr_pkg::CONT_RX_EN_BIT];
				end
				ADDR_W'(ausr_pkg::TX_CONTROL_STATUS_IDX): begin
					tx_ninth_en_reg  <= reg_wdata[ausr_pkg::TX_NINTH_EN_BIT];
					tx_enable_reg    <= reg_wdata[ausr_pkg::TX_ENABLE_BIT];
					clocked_mode_reg <= reg_wdata[ausr_pkg::CLOCKED_MODE_BIT];
					high_speed_reg   <= reg_wdata[ausr_pkg::HIGH_SPEED_BIT];
					tx_ninth_val_reg <= reg_wdata[ausr_pkg::TX_NINTH_VAL_BIT];
				end
				default: ;
			endcase
		end
	end

	// Read data valid only in the cycle after the strobe; unmapped read zero
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_W'(ausr_pkg::IRQ_CONTROL_IDX):      reg_rdata <= irq_control_reg;
				ADDR_W'(ausr_pkg::PERIPH_FLAGS_1_IDX):   reg_rdata <= {2'h0, rx_full_reg, tx_empty_flag_reg, 4'h0};
				ADDR_W'(ausr_pkg::PERIPH_ENABLES_1_IDX): reg_rdata <= enables_reg;
				ADDR_W'(ausr_pkg::PERIPH_PRIO_1_IDX):    reg_rdata <= priorities_reg;
				ADDR_W'(ausr_pkg::RX_CONTROL_STATUS_IDX):
					reg_rdata <= {port_enable_reg, rx_ninth_en_reg, 1'b0, cont_rx_en_reg, 1'b0,
						framing_err_reg, overrun_err_reg, rx_ninth_reg};  // Status read first
				ADDR_W'(ausr_pkg::RX_BUFFER_IDX):        reg_rdata <= rx_buf_reg;
				ADDR_W'(ausr_pkg::TX_HOLDING_BUFFER_IDX): reg_rdata <= tx_buf_reg;
				ADDR_W'(ausr_pkg::TX_CONTROL_STATUS_IDX):
					reg_rdata <= {1'b0, tx_ninth_en_reg, tx_enable_reg, clocked_mode_reg, 1'b0,
						high_speed_reg, (tx_state_reg == TX_IDLE), tx_ninth_val_reg};
				ADDR_W'(ausr_pkg::RATE_CONTROL_IDX):     reg_rdata <= {4'h0, wide_divider_reg, 3'h0};
				ADDR_W'(ausr_pkg::DIVISOR_HIGH_IDX):     reg_rdata <= divisor_high_reg;
				ADDR_W'(ausr_pkg::DIVISOR_LOW_IDX):      reg_rdata <= divisor_low_reg;
				default:                                 reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************
	// Baud rate divider
	// ****************************************
	// Divider tick every divisor+1 clocks; x64 mode prescales by four
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !cfg.active) begin
			brg_cnt_reg <= 16'h0000;
			pre_cnt_reg <= 2'h0;
		end else if (brg_cnt_reg == 16'h0000) begin
			brg_cnt_reg <= cfg.divisor;
			pre_cnt_reg <= pre_cnt_reg + 2'h1;
		end else begin
			brg_cnt_reg <= brg_cnt_reg - 16'h0001;
		end
	end

	assign brg_tick = cfg.active && (brg_cnt_reg == 16'h0000);
	assign s16_tick = brg_tick && (cfg.x16_mode || pre_cnt_reg == ausr_pkg::X64_PRESCALE);

	// ****************************************
	// Transmitter
	// ****************************************
	// Reload only from idle, i.e. after the stop bit
	assign tx_load = (tx_state_reg == TX_IDLE) && tx_full_reg && tx_enable_reg && cfg.active;

	// Holding buffer; disabled transmitter drops it so enabling shows empty
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tx_buf_reg  <= 8'h00;
			tx_full_reg <= 1'b0;
		end else begin
			if (wr_tx_buf) begin
				tx_buf_reg <= reg_wdata;
			end
			if (!tx_enable_reg) begin
				tx_full_reg <= 1'b0;
			end else if (wr_tx_buf) begin
				tx_full_reg <= 1'b1;  // Load wins over transfer in the same cycle
			end else if (tx_load) begin
				tx_full_reg <= 1'b0;  // One-cycle transfer empties buffer
			end
		end
	end

	// Flag lags buffer state one cycle, readable from second cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tx_empty_flag_reg <= 1'b0;
		end else begin
			tx_empty_flag_reg <= tx_enable_reg & ~tx_full_reg;
		end
	end

	// Transmit shifter state machine
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !cfg.active) begin
			tx_state_reg <= TX_IDLE;
			tx_shift_reg <= 9'h000;
			tx_tick_reg  <= 4'h0;
			tx_bits_reg  <= 4'h0;
		end else begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift_reg <= {tx_ninth_val_reg, tx_buf_reg};  // Stored ninth bit
						tx_bits_reg  <= tx_ninth_en_reg ? 4'h8 : 4'h7;    // Eight or nine bits
						tx_tick_reg  <= ausr_pkg::TICKS_PER_BIT;
						tx_state_reg <= TX_START;
					end
				end
				TX_START: begin
					if (s16_tick) begin
						tx_tick_reg <= tx_tick_reg - 4'h1;
						if (tx_tick_reg == 4'h0) begin
							tx_state_reg <= TX_DATA;
						end
					end
				end
				TX_DATA: begin
					if (s16_tick) begin
						tx_tick_reg <= tx_tick_reg - 4'h1;
						if (tx_tick_reg == 4'h0) begin
							tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};  // LSB first
							tx_bits_reg  <= tx_bits_reg - 4'h1;
							if (tx_bits_reg == 4'h0) begin
								tx_state_reg <= TX_STOP;
							end
						end
					end
				end
				TX_STOP: begin
					if (s16_tick) begin
						tx_tick_reg <= tx_tick_reg - 4'h1;
						if (tx_tick_reg == 4'h0) begin
							tx_state_reg <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Line level: idle and stop high, start low
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			serial_output <= 1'b1;
		end else begin
			serial_output <= (tx_state_reg == TX_START) ? 1'b0 :
				(tx_state_reg == TX_DATA) ? tx_shift_reg[0] : 1'b1;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	// Recovery at sixteen samples per bit, one sample per bit shifted
	always_ff @(posedge sys_clk) begin
		if (!rst_n || !cfg.active || !cont_rx_en_reg || overrun_err_reg) begin
			rx_state_reg   <= RX_IDLE;
			rx_shift_reg   <= 9'h000;
			rx_tick_reg    <= 4'h0;
			rx_bits_reg    <= 4'h0;
			rx_done_reg    <= 1'b0;
			rx_stop_ok_reg <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			unique case (rx_state_reg)
				RX_IDLE: begin
					if (s16_tick && !serial_input) begin
						rx_tick_reg  <= ausr_pkg::MID_BIT_TICK;
						rx_state_reg <= RX_START;
					end
				end
				RX_START: begin
					if (s16_tick) begin
						rx_tick_reg <= rx_tick_reg - 4'h1;
						if (rx_tick_reg == 4'h0) begin
							rx_tick_reg  <= ausr_pkg::TICKS_PER_BIT;
							rx_bits_reg  <= rx_ninth_en_reg ? 4'h8 : 4'h7;
							rx_state_reg <= serial_input ? RX_IDLE : RX_DATA;  // Glitch rejected
						end
					end
				end
				RX_DATA: begin
					if (s16_tick) begin
						rx_tick_reg <= rx_tick_reg - 4'h1;
						if (rx_tick_reg == 4'h0) begin
							rx_tick_reg  <= ausr_pkg::TICKS_PER_BIT;
							rx_shift_reg <= rx_ninth_en_reg ? {serial_input, rx_shift_reg[8:1]}
								: {1'b0, serial_input, rx_shift_reg[7:1]};  // LSB first
							rx_bits_reg  <= rx_bits_reg - 4'h1;
							if (rx_bits_reg == 4'h0) begin
								rx_state_reg <= RX_STOP;
							end
						end
					end
				end
				RX_STOP: begin
					if (s16_tick) begin
						rx_tick_reg <= rx_tick_reg - 4'h1;
						if (rx_tick_reg == 4'h0) begin
							rx_stop_ok_reg <= serial_input;
							rx_done_reg    <= 1'b1;
							rx_state_reg   <= RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Receive buffer, complete flag, error status
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rx_buf_reg      <= 8'h00;
			rx_ninth_reg    <= 1'b0;
			rx_full_reg     <= 1'b0;
			framing_err_reg <= 1'b0;
			overrun_err_reg <= 1'b0;
		end else begin
			if (rx_done_reg && !rx_full_reg) begin
				rx_buf_reg      <= rx_shift_reg[7:0];
				rx_ninth_reg    <= rx_ninth_en_reg & rx_shift_reg[8];
				framing_err_reg <= ~rx_stop_ok_reg;  // Low stop bit
				rx_full_reg     <= 1'b1;             // New frame wins over read
			end else if (rd_rx_buf) begin
				rx_full_reg <= 1'b0;
			end
			if (!cont_rx_en_reg) begin
				overrun_err_reg <= 1'b0;
			end else if (rx_done_reg && rx_full_reg) begin
				overrun_err_reg <= 1'b1;  // Frame lost, buffer still full
			end
		end
	end

	// ****************************************
	// Interrupt gating
	// ****************************************
	assign tx_irq = tx_empty_flag_reg & enables_reg[ausr_pkg::TX_EMPTY_BIT];
	assign rx_irq = rx_full_reg & enables_reg[ausr_pkg::RX_COMPLETE_BIT];

	// Request reaches processor only with both enables
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cpu_irq <= 1'b0;
		end else begin
			cpu_irq <= irq_control_reg[ausr_pkg::GLOBAL_IRQ_EN_BIT] &
				irq_control_reg[ausr_pkg::PERIPH_IRQ_EN_BIT] & (tx_irq | rx_irq);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_tx_write;
		wr_tx_buf && tx_enable_reg;
	endsequence

	sequence s_rx_lost;
		rx_done_reg && rx_full_reg && cont_rx_en_reg;
	endsequence

	a_flag_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_tx_write |-> ##2 !tx_empty_flag_reg)
		else $error("empty flag not cleared two cycles after buffer write");

	a_load_transfer: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tx_load && !wr_tx_buf |=> (tx_state_reg == TX_START) && !tx_full_reg ##1 tx_empty_flag_reg)
		else $error("buffer transfer did not empty buffer and set flag");

	a_no_reload_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(tx_state_reg != TX_IDLE) && tx_full_reg && tx_enable_reg |=> tx_full_reg)
		else $error("shifter reloaded before stop bit finished");

	a_start_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(tx_state_reg == TX_START) |=> !serial_output)
		else $error("start bit not low on the line");

	a_enable_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(tx_enable_reg) && !wr_tx_buf |=> tx_empty_flag_reg)
		else $error("enabling transmitter did not set empty flag");

	a_async_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		clocked_mode_reg |=> (tx_state_reg == TX_IDLE) && (rx_state_reg == RX_IDLE) && serial_output)
		else $error("async logic ran in clocked mode");

	a_rx_complete: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rx_done_reg && !rx_full_reg |=> rx_full_reg && (framing_err_reg == !$past(rx_stop_ok_reg)))
		else $error("completed frame not flagged with its stop status");

	a_overrun_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_rx_lost |=> overrun_err_reg && (rx_state_reg == RX_IDLE))
		else $error("overrun not raised on lost frame");

	a_error_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!cont_rx_en_reg |=> !overrun_err_reg)
		else $error("overrun survived receive disable");

	a_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_irq |-> $past(irq_control_reg[ausr_pkg::GLOBAL_IRQ_EN_BIT] && irq_control_reg[ausr_pkg::PERIPH_IRQ_EN_BIT]))
		else $error("interrupt raised without both enables");

	a_tx_irq_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cpu_irq && !$past(rx_irq) |-> $past(enables_reg[ausr_pkg::TX_EMPTY_BIT] && tx_empty_flag_reg))
		else $error("transmit interrupt without its enable");

endmodule : ausr_core

// File: common/ausr_pkg.sv
/*
 * Constants, register map and carrier types for the asynchronous serial port.
 * Assumes a single clock domain and a plain strobe-based register port.
 */
package ausr_pkg;

	// ****************************************
	// Register indices on the register port
	// ****************************************
	localparam logic [3:0] IRQ_CONTROL_IDX        = 4'h0;
	localparam logic [3:0] PERIPH_FLAGS_1_IDX     = 4'h1;
	localparam logic [3:0] PERIPH_ENABLES_1_IDX   = 4'h2;
	localparam logic [3:0] PERIPH_PRIO_1_IDX      = 4'h3;
	localparam logic [3:0] RX_CONTROL_STATUS_IDX  = 4'h4;
	localparam logic [3:0] RX_BUFFER_IDX          = 4'h5;
	localparam logic [3:0] TX_HOLDING_BUFFER_IDX  = 4'h6;
	localparam logic [3:0] TX_CONTROL_STATUS_IDX  = 4'h7;
	localparam logic [3:0] RATE_CONTROL_IDX       = 4'h8;
	localparam logic [3:0] DIVISOR_HIGH_IDX       = 4'h9;
	localparam logic [3:0] DIVISOR_LOW_IDX        = 4'ha;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int GLOBAL_IRQ_EN_BIT     = 7;
	localparam int PERIPH_IRQ_EN_BIT     = 6;
	localparam int RX_COMPLETE_BIT       = 5;
	localparam int TX_EMPTY_BIT          = 4;
	localparam int PORT_ENABLE_BIT       = 7;
	localparam int RX_NINTH_EN_BIT       = 6;
	localparam int CONT_RX_EN_BIT        = 4;
	localparam int FRAMING_ERR_BIT       = 2;
	localparam int OVERRUN_ERR_BIT       = 1;
	localparam int RX_NINTH_VAL_BIT      = 0;
	localparam int TX_NINTH_EN_BIT       = 6;
	localparam int TX_ENABLE_BIT         = 5;
	localparam int CLOCKED_MODE_BIT      = 4;
	localparam int HIGH_SPEED_BIT        = 2;
	localparam int SHIFTER_EMPTY_BIT     = 1;
	localparam int TX_NINTH_VAL_BIT      = 0;
	localparam int WIDE_DIVIDER_BIT      = 3;

	// ****************************************
	// Reset values and timing counts
	// ****************************************
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [3:0] TICKS_PER_BIT  = 4'hf;   // Sixteen sample ticks, counted 15..0
	localparam logic [3:0] MID_BIT_TICK   = 4'h7;   // Start bit checked at half a bit
	localparam logic [1:0] X64_PRESCALE   = 2'h3;   // Four divider ticks per sample tick

	// Frame settings shared by transmitter and receiver
	typedef struct packed {
		logic        active;     // Port enabled and not in clocked mode
		logic        x16_mode;   // Divider output at sixteen times the bit rate
		logic [15:0] divisor;
	} ausr_frame_cfg_t;

endpackage : ausr_pkg

// File: verification/ausr_node.sv
/*
 * Remote serial node model: sends frames into the port, captures its frames.
 * Assumes an idle-high line and bit_clks clocks in each bit.
 */
module ausr_node (
	input  wire logic       sys_clk,
	input  wire logic       line_in,
	input  wire logic       nine_bits,
	input  wire logic [7:0] bit_clks,
	output logic            line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] rx_word;
	logic       rx_stop;
	int         rx_count;

	// One frame out: start, data, stop, one idle bit
	task automatic send(input logic [8:0] d, input logic stop_v);
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge sys_clk);
		for (int i = 0; i < (nine_bits ? 9 : 8); i++) begin
			line_out <= d[i];
			repeat (bit_clks) @(posedge sys_clk);
		end
		line_out <= stop_v;
		repeat (bit_clks) @(posedge sys_clk);
		line_out <= 1'b1;
		repeat (bit_clks) @(posedge sys_clk);
	endtask : send

	// Idle high, then capture each frame at mid-bit
	initial begin
		line_out = 1'b1;
		rx_count = 0;
		forever begin
			@(negedge line_in);
			repeat (bit_clks / 2) @(posedge sys_clk);
			rx_word = 9'h000;
			for (int i = 0; i < (nine_bits ? 9 : 8); i++) begin
				repeat (bit_clks) @(posedge sys_clk);
				rx_word[i] = line_in;
			end
			repeat (bit_clks) @(posedge sys_clk);
			rx_stop = line_in;
			rx_count++;
		end
	end
endmodule : ausr_node

// File: verification/ausr_core_tb_top.sv
/*
 * Testbench for the serial core: register master, scenarios, verdict.
 * Assumes the node model on the serial pins and a 16-clock bit, 64 clocks for the one x64 word.
 */
module ausr_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] A_IC = ausr_pkg::IRQ_CONTROL_IDX;
	localparam logic [3:0] A_FL = ausr_pkg::PERIPH_FLAGS_1_IDX;
	localparam logic [3:0] A_EN = ausr_pkg::PERIPH_ENABLES_1_IDX;
	localparam logic [3:0] A_RC = ausr_pkg::RX_CONTROL_STATUS_IDX;
	localparam logic [3:0] A_RB = ausr_pkg::RX_BUFFER_IDX;
	localparam logic [3:0] A_TB = ausr_pkg::TX_HOLDING_BUFFER_IDX;
	localparam logic [3:0] A_TC = ausr_pkg::TX_CONTROL_STATUS_IDX;
	localparam logic [7:0] HS = 8'h04, TE = 8'h20, PE = 8'h80, CR = 8'h10;
	logic       sys_clk, rst_n, reg_wr, reg_rd, serial_input, serial_output, cpu_irq, nine_bits;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, bit_clks, v;
	int         fail_count = 0, n_compared = 0, cycles = 0;

	ausr_core #(.ADDR_W(4)) i_ausr_core (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.serial_input(serial_input), .serial_output(serial_output), .cpu_irq(cpu_irq));
	ausr_node i_ausr_node (.sys_clk(sys_clk), .line_in(serial_output), .nine_bits(nine_bits),
		.bit_clks(bit_clks), .line_out(serial_input));

	// ****************************************
	// Clock, hang limit, bus and compare tasks
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Cut a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Write, then one idle edge so strobes never touch
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	// Read strobe for one cycle, data taken at the next edge
	task automatic rdm(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		v = reg_rdata;
		chk({1'b0, v & m}, {1'b0, e});
	endtask : rdm
	// Interrupt line one edge after a register write has settled
	task automatic irq_is(input logic e);
		@(posedge sys_clk);
		chk({8'h00, cpu_irq}, {8'h00, e});
	endtask : irq_is
	task automatic wait_rx(input int n);
		for (int k = 0; k < 3000 && i_ausr_node.rx_count < n; k++) @(posedge sys_clk);
		chk(9'(i_ausr_node.rx_count >= n), 9'h001);
	endtask : wait_rx
	task automatic tx_word(input logic [8:0] d);
		int n;
		n = i_ausr_node.rx_count + 1;
		wr(A_TB, d[7:0]);
		wait_rx(n);
		chk(i_ausr_node.rx_word, d);
		chk({8'h00, i_ausr_node.rx_stop}, 9'h001);
	endtask : tx_word

	// Scenarios
	task automatic t_regs();
		rdm(A_IC, 8'hff, 8'h00);
		rdm(A_FL, 8'hff, 8'h00);
		rdm(A_RC, 8'hff, 8'h00);
		wr(ausr_pkg::PERIPH_PRIO_1_IDX, 8'h5a);
		rdm(ausr_pkg::PERIPH_PRIO_1_IDX, 8'hff, 8'h5a);
		wr(4'hb, 8'hff);
		rdm(4'hb, 8'hff, 8'h00);
		wr(ausr_pkg::DIVISOR_LOW_IDX, 8'h00);
		wr(A_TC, HS);
		wr(A_RC, PE);
		rdm(A_FL, 8'h10, 8'h00);
		wr(A_TC, HS | TE);
		rdm(A_FL, 8'h10, 8'h10);
		wr(A_FL, 8'h00);
		rdm(A_FL, 8'h10, 8'h10);
	endtask : t_regs
	task automatic t_tx();
		int n;
		n = i_ausr_node.rx_count + 1;
		wr(A_TB, 8'ha5);
		repeat (4) @(posedge sys_clk);
		rdm(A_TC, 8'h02, 8'h00);
		wr(A_TB, 8'h3c);
		rdm(A_FL, 8'h10, 8'h00);
		wait_rx(n);
		chk(i_ausr_node.rx_word, 9'h0a5);
		wait_rx(n + 1);
		chk(i_ausr_node.rx_word, 9'h03c);
		rdm(A_FL, 8'h10, 8'h10);
		repeat (40) @(posedge sys_clk);
		rdm(A_TC, 8'h02, 8'h02);
		nine_bits <= 1'b1;
		wr(A_TC, HS | TE | 8'h41);
		tx_word(9'h15a);
		nine_bits <= 1'b0;
		bit_clks <= 8'd64;
		wr(A_TC, TE);
		tx_word(9'h096);
		bit_clks <= 8'd16;
		wr(ausr_pkg::RATE_CONTROL_IDX, 8'h08);
		rdm(ausr_pkg::RATE_CONTROL_IDX, 8'hff, 8'h08);
		tx_word(9'h0e1);
		n = i_ausr_node.rx_count;
		wr(A_TC, HS | TE | 8'h10);
		wr(A_TB, 8'h77);
		repeat (200) @(posedge sys_clk);
		chk(9'(i_ausr_node.rx_count - n), 9'h000);
		wr(A_TC, HS);
		wr(A_TC, HS | TE);
	endtask : t_tx
	task automatic t_rx();
		wr(A_RC, PE | CR);
		i_ausr_node.send(9'h0c3, 1'b1);
		rdm(A_FL, 8'h20, 8'h20);
		rdm(A_RC, 8'h07, 8'h00);
		rdm(A_RB, 8'hff, 8'hc3);
		rdm(A_FL, 8'h20, 8'h00);
		nine_bits <= 1'b1;
		wr(A_RC, PE | CR | 8'h40);
		i_ausr_node.send(9'h181, 1'b1);
		rdm(A_RC, 8'h01, 8'h01);
		rdm(A_RB, 8'hff, 8'h81);
		nine_bits <= 1'b0;
		wr(A_RC, PE | CR);
	endtask : t_rx
	task automatic t_irq_err();
		i_ausr_node.send(9'h011, 1'b1);
		wr(A_EN, 8'h20);
		wr(A_IC, 8'hc0);
		irq_is(1'b1);
		wr(A_IC, 8'h80);
		irq_is(1'b0);
		i_ausr_node.send(9'h022, 1'b1);
		rdm(A_RC, 8'h02, 8'h02);
		rdm(A_RB, 8'hff, 8'h11);
		wr(A_RC, PE);
		rdm(A_RC, 8'h02, 8'h00);
		wr(A_EN, 8'h10);
		wr(A_IC, 8'hc0);
		irq_is(1'b1);
		wr(A_EN, 8'h00);
		irq_is(1'b0);
		wr(A_RC, PE | CR);
		i_ausr_node.send(9'h055, 1'b0);
		rdm(A_RC, 8'h04, 8'h04);
	endtask : t_irq_err

	// Reset, then every scenario in turn
	initial begin
		rst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		nine_bits = 1'b0;
		bit_clks = 8'd16;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_tx();
		t_rx();
		t_irq_err();
		print_verdict();
	end
endmodule : ausr_core_tb_top
